// ===== fsr_dev_model.sv
// behavioural model of the transmitting device lane
`timescale 1ns/1ps
`include "fsr_regs.vh"
module fsr_dev_model
(
   // clock
   input wire clk,
   // device control pins
   input wire link_enable,
   input wire [3:0] preemph,
   // fault orders
   input wire bad_sh,
   input wire bad_pilot,
   input wire bad_flag,
   input wire flip_data,
   // blocks towards the controller
   output logic blk_valid = 1'b0,
   output logic [1:0] blk_sh = 2'h1,
   output logic [63:0] blk_payload = 64'h0
);
   logic [4:0] bi_ff = 5'h0;
   logic [31:0] cnt_ff = 32'h0;
   logic [25:0] par_ff = 26'h0;
   logic [25:0] txp_ff = 26'h0;
   logic [3:0] pe_ff = 4'h0;
   logic [31:0] shs;
   logic [63:0] d;
   // serial generator, payload bit 0 first
   function automatic [25:0] par_step(input [25:0] p, input [63:0] x);
      integer i;
      begin
         par_step = p;
         for (i = 0; i < 64; i = i + 1)
            par_step = {par_step[24:0], 1'b0} ^ ((par_step[25] ^ x[i]) ? `FSR_PAR_POLY : 26'h0);
      end
   endfunction
   // stream of this multiblock carries last parity, flag set since E is 1
   always_comb
   begin
      for (int j = 0; j < 22; j++)
         shs[j] = txp_ff[25 - j];
      for (int j = 23; j < 27; j++)
         shs[j] = txp_ff[26 - j];
      shs[22] = 1'b1 ^ bad_flag;
      shs[31:27] = {1'b1 ^ bad_pilot, 4'h0};
      d = {cnt_ff * 32'h9e3779b9, cnt_ff ^ 32'h5a5a0f0f};
   end
   // one block per cycle, no alignment sequence, idle lines toggle when off
   always @(posedge clk)
   begin
      pe_ff <= preemph;
      if (!link_enable)
      begin
         blk_valid <= 1'b0;
         blk_sh <= ~blk_sh;
         blk_payload <= ~blk_payload;
         bi_ff <= 5'h0;
         par_ff <= 26'h0;
         txp_ff <= 26'h0;
      end
      else
      begin
         blk_valid <= 1'b1;
         blk_sh <= bad_sh ? 2'h0 : (shs[bi_ff] ? `FSR_SH_ONE : `FSR_SH_ZERO);
         blk_payload <= d ^ {flip_data && bi_ff == `FSR_MB_LAST, 63'h0};
         bi_ff <= bi_ff + 5'h1;
         cnt_ff <= cnt_ff + 32'h1;
         par_ff <= (bi_ff == `FSR_MB_LAST) ? 26'h0 : par_step(par_ff, d);
         if (bi_ff == `FSR_MB_LAST)
            txp_ff <= par_step(par_ff, d);
      end
   end
endmodule

// ===== fsr_regs.vh
// constants for the sync header stream receive-side controller
`ifndef FSR_REGS_VH
`define FSR_REGS_VH
// ----------------------------------------------------------------
// parity generator
// ----------------------------------------------------------------
`define FSR_PAR_W 26
`define FSR_PAR_POLY 26'h0220211
`define FSR_PAR_ZERO 26'h0000000
// ----------------------------------------------------------------
// sync header stream layout
// ----------------------------------------------------------------
`define FSR_MB_LAST 5'h1f
`define FSR_SHS_EMB_BIT 22
`define FSR_SHS_P_HI_END 21
`define FSR_SHS_P_LO_POS 23
`define FSR_PILOT 5'h01
`define FSR_SH_ONE 2'h1
`define FSR_SH_ZERO 2'h2
// ----------------------------------------------------------------
// monitoring windows and thresholds
// ----------------------------------------------------------------
`define FSR_BLK_GOOD_CNT 7'h40
`define FSR_BLK_WIN 7'h40
`define FSR_BLK_ERR_MAX 3'h4
`define FSR_MB_CONFIRM 2'h3
`define FSR_MB_WIN 4'h8
`define FSR_MB_ERR_MAX 3'h2
`define FSR_EMB_WIN 4'h8
`define FSR_EMB_ERR_MAX 3'h2
// ----------------------------------------------------------------
// link enable sequencing, cycles of the 50 ns clock
// ----------------------------------------------------------------
`define FSR_SETTLE_CYC 8'h14
`define FSR_PE_RESET 4'h0
`endif

// ===== fsr_rx_ctrl.v
// receive-side controller for the fec sync header stream link
`timescale 1ns/1ps
`include "fsr_regs.vh"

// Contract
// - receiver forms syndrome, nonzero flags error
// - first-bit error seen no sooner than 58 blocks
// - confirm pilot position over several multiblocks
// - start buffering at next boundary after alignment
// - release at first release point after start
// - several bad headers in window drop block sync
// - several bad pilots in window drop multiblock sync
// - repeated wrong flag drops extended multiblock sync
// - request sysref after multiblock sync loss
// - clear enable, change settings, then set enable
module fsr_rx_ctrl
(
   // clock and reset
   input wire clk,
   input wire srst,
   // received blocks from the deserializer gearbox, release clock and delay, same clock
   input wire blk_valid,
   input wire [1:0] blk_sh,
   input wire [63:0] blk_payload,
   input wire local_extended_multiblock_clock,
   input wire [7:0] release_buffer_delay,
   // user configuration orders
   input wire cfg_req,
   input wire [3:0] cfg_preemph,
   output wire cfg_busy,
   // device control pins
   output reg link_enable_ff,
   output reg [3:0] serializer_preemphasis_level_ff,
   // alignment status
   output reg block_sync_ff,
   output reg mb_lock_ff,
   output reg emb_lock_ff,
   output reg restart_block_align_ff,
   output reg sysref_request_ff,
   // elastic buffer control
   output reg buffer_start_ff,
   output reg buffer_release_ff,
   // error correction results
   output reg [25:0] syndrome_ff,
   output reg syndrome_valid_ff,
   output reg fec_error_ff
);

// ----------------------------------------------------------------
// declarations
// ----------------------------------------------------------------
localparam CS_IDLE = 2'h0;
localparam CS_DIS = 2'h1;
localparam CS_APPLY = 2'h2;
localparam CS_EN = 2'h3;

reg [1:0] cs_ff;
reg [7:0] cs_cnt_ff;
reg [3:0] pe_hold_ff;
reg [25:0] par_ff;
reg [25:0] prev_par_ff;
reg prev_par_ok_ff;
reg [31:0] shs_ff;
reg [4:0] blk_cnt_ff;
reg [6:0] good_cnt_ff;
reg [6:0] bwin_ff;
reg [2:0] berr_ff;
reg [1:0] conf_ff;
reg [3:0] mwin_ff;
reg [2:0] merr_ff;
reg [2:0] eerr_ff;
reg [3:0] ewin_ff;
reg buf_on_ff;
reg rel_arm_ff;
reg [7:0] rel_cnt_ff;
reg rel_run_ff;

wire sh_bad;
wire sh_bit;
wire [31:0] shs_full;
wire mb_end;
wire pilot_ok;
wire emb_ok;
wire [25:0] rx_par;
wire [25:0] par_nxt;
wire [25:0] par_base;
wire run;

// ----------------------------------------------------------------
// parity generator
// ----------------------------------------------------------------
// one block of 64 bits, bit 0 first, through the serial divider
function [25:0] fsr_par_step;
   input [25:0] s;
   input [63:0] d;
   integer i;
   reg [25:0] t;
   reg fb;
   begin
      t = s;
      for (i = 0; i < 64; i = i + 1)
      begin
         fb = d[i] ^ t[25];
         t = {t[24:0], 1'b0} ^ (fb ? `FSR_PAR_POLY : `FSR_PAR_ZERO);
      end
      fsr_par_step = t;
   end
endfunction

// header decoding: 01 is one, 10 is zero, 00 and 11 are faults
assign sh_bad = (blk_sh != `FSR_SH_ONE) && (blk_sh != `FSR_SH_ZERO);
assign sh_bit = (blk_sh == `FSR_SH_ONE);
assign run = link_enable_ff && block_sync_ff;
assign mb_end = (blk_cnt_ff == `FSR_MB_LAST);

// stream word with the current block's bit placed at its index
assign shs_full = {sh_bit, shs_ff[31:1]};
// pilot read in transmission order, bit 27 first
assign pilot_ok = ({shs_full[27], shs_full[28], shs_full[29], shs_full[30], shs_full[31]}
   == `FSR_PILOT);
assign emb_ok = shs_full[`FSR_SHS_EMB_BIT]; // single-multiblock extension
// received parity field unpacked from stream positions
genvar g;
generate
   for (g = 0; g < 26; g = g + 1)
   begin : g_rx
      if (g >= 4)
      begin : g_hi
         assign rx_par[g] = shs_full[25 - g];
      end
      else
      begin : g_lo
         assign rx_par[g] = shs_full[26 - g];
      end
   end
endgenerate

// stages start from zero at block 0 of each multiblock
assign par_base = (blk_cnt_ff == 5'h00) ? `FSR_PAR_ZERO : par_ff;
assign par_nxt = fsr_par_step(par_base, blk_payload);
assign cfg_busy = (cs_ff != CS_IDLE);

// ----------------------------------------------------------------
// link enable sequencing
// ----------------------------------------------------------------
// drop enable, apply settings while disabled, then re-enable
always @(posedge clk)
begin
   if (srst)
   begin
      cs_ff <= CS_EN;
      cs_cnt_ff <= 8'h00;
      pe_hold_ff <= `FSR_PE_RESET;
      link_enable_ff <= 1'b0;
      serializer_preemphasis_level_ff <= `FSR_PE_RESET;
   end
   else
   begin
      case (cs_ff)
         CS_IDLE:
         begin
            if (cfg_req)
            begin
               pe_hold_ff <= cfg_preemph;
               link_enable_ff <= 1'b0;
               cs_cnt_ff <= 8'h00;
               cs_ff <= CS_DIS;
            end
         end
         CS_DIS:
         begin
            cs_cnt_ff <= cs_cnt_ff + 8'h01;
            if (cs_cnt_ff == `FSR_SETTLE_CYC - 8'h01)
            begin
               serializer_preemphasis_level_ff <= pe_hold_ff;
               cs_cnt_ff <= 8'h00;
               cs_ff <= CS_APPLY;
            end
         end
         CS_APPLY:
         begin
            cs_cnt_ff <= cs_cnt_ff + 8'h01;
            if (cs_cnt_ff == `FSR_SETTLE_CYC - 8'h01)
            begin
               cs_cnt_ff <= 8'h00;
               cs_ff <= CS_EN;
            end
         end
         CS_EN:
         begin
            link_enable_ff <= 1'b1;
            cs_ff <= CS_IDLE;
         end
         default:
         begin
            cs_ff <= CS_IDLE;
         end
      endcase
   end
end

// ----------------------------------------------------------------
// block synchronisation monitor
// ----------------------------------------------------------------
// gain after a run of good headers, lose on errors within a window
always @(posedge clk)
begin
   if (srst || !link_enable_ff)
   begin
      block_sync_ff <= 1'b0;
      good_cnt_ff <= 7'h00;
      bwin_ff <= 7'h00;
      berr_ff <= 3'h0;
      restart_block_align_ff <= 1'b0;
   end
   else
   begin
      restart_block_align_ff <= 1'b0;
      if (blk_valid && !block_sync_ff)
      begin
         good_cnt_ff <= sh_bad ? 7'h00 : good_cnt_ff + 7'h01;
         if (!sh_bad && good_cnt_ff == `FSR_BLK_GOOD_CNT - 7'h01)
         begin
            block_sync_ff <= 1'b1;
            bwin_ff <= 7'h00;
            berr_ff <= 3'h0;
         end
      end
      else if (blk_valid)
      begin
         bwin_ff <= (bwin_ff == `FSR_BLK_WIN - 7'h01) ? 7'h00 : bwin_ff + 7'h01;
         if (sh_bad && berr_ff == `FSR_BLK_ERR_MAX - 3'h1)
         begin
            block_sync_ff <= 1'b0;
            good_cnt_ff <= 7'h00;
            restart_block_align_ff <= 1'b1;
         end
         else if (bwin_ff == `FSR_BLK_WIN - 7'h01)
            berr_ff <= sh_bad ? 3'h1 : 3'h0; // up to three errors per window are tolerated
         else if (sh_bad)
            berr_ff <= berr_ff + 3'h1;
      end
   end
end

// ----------------------------------------------------------------
// multiblock and extended multiblock alignment
// ----------------------------------------------------------------
// hunt for the pilot, confirm its place, then police it
always @(posedge clk)
begin
   if (srst || !run)
   begin
      shs_ff <= 32'h00000000;
      blk_cnt_ff <= 5'h00;
      conf_ff <= 2'h0;
      mb_lock_ff <= 1'b0;
      emb_lock_ff <= 1'b0;
      mwin_ff <= 4'h0;
      merr_ff <= 3'h0;
      ewin_ff <= 4'h0;
      eerr_ff <= 3'h0;
      sysref_request_ff <= 1'b0;
   end
   else
   begin
      sysref_request_ff <= 1'b0;
      if (blk_valid)
      begin
         shs_ff <= {sh_bit, shs_ff[31:1]};
         blk_cnt_ff <= blk_cnt_ff + 5'h01;
         if (!mb_lock_ff)
         begin
            // the first pilot candidate realigns the count; repeats at the multiblock end confirm it
            if (pilot_ok && (mb_end || conf_ff == 2'h0))
            begin
               blk_cnt_ff <= 5'h00;
               conf_ff <= conf_ff + 2'h1;
               if (conf_ff == `FSR_MB_CONFIRM - 2'h1)
               begin
                  mb_lock_ff <= 1'b1;
                  mwin_ff <= 4'h0;
                  merr_ff <= 3'h0;
               end
            end
            else if (mb_end)
               conf_ff <= 2'h0;
         end
         else if (mb_end)
         begin
            mwin_ff <= (mwin_ff == `FSR_MB_WIN - 4'h1) ? 4'h0 : mwin_ff + 4'h1;
            ewin_ff <= (ewin_ff == `FSR_EMB_WIN - 4'h1) ? 4'h0 : ewin_ff + 4'h1;
            if (!pilot_ok && merr_ff == `FSR_MB_ERR_MAX - 3'h1)
            begin
               mb_lock_ff <= 1'b0;
               emb_lock_ff <= 1'b0;
               conf_ff <= 2'h0;
               sysref_request_ff <= 1'b1;
            end
            else if (mwin_ff == `FSR_MB_WIN - 4'h1)
               merr_ff <= pilot_ok ? 3'h0 : 3'h1;
            else if (!pilot_ok)
               merr_ff <= merr_ff + 3'h1;
            // every multiblock is the final one, so the flag must be set
            if (!emb_ok && eerr_ff == `FSR_EMB_ERR_MAX - 3'h1)
            begin
               emb_lock_ff <= 1'b0;
               sysref_request_ff <= 1'b1;
               eerr_ff <= 3'h0;
            end
            else
            begin
               if (emb_ok && pilot_ok)
                  emb_lock_ff <= 1'b1;
               if (ewin_ff == `FSR_EMB_WIN - 4'h1)
                  eerr_ff <= emb_ok ? 3'h0 : 3'h1;
               else if (!emb_ok)
                  eerr_ff <= eerr_ff + 3'h1;
            end
         end
      end
   end
end

// ----------------------------------------------------------------
// parity check
// ----------------------------------------------------------------
// syndrome at the end of the multiblock that carries the parity
always @(posedge clk)
begin
   if (srst || !mb_lock_ff)
   begin
      par_ff <= `FSR_PAR_ZERO;
      prev_par_ff <= `FSR_PAR_ZERO;
      prev_par_ok_ff <= 1'b0;
      syndrome_ff <= `FSR_PAR_ZERO;
      syndrome_valid_ff <= 1'b0;
      fec_error_ff <= 1'b0;
   end
   else
   begin
      syndrome_valid_ff <= 1'b0;
      fec_error_ff <= 1'b0;
      if (blk_valid)
      begin
         par_ff <= par_nxt;
         if (mb_end)
         begin
            prev_par_ff <= par_nxt;
            prev_par_ok_ff <= 1'b1;
            if (prev_par_ok_ff)
            begin
               syndrome_ff <= prev_par_ff ^ rx_par;
               syndrome_valid_ff <= 1'b1;
               fec_error_ff <= (prev_par_ff != rx_par);
            end
         end
      end
   end
end

// ----------------------------------------------------------------
// elastic buffer start and release
// ----------------------------------------------------------------
// no alignment sequence: start at the boundary after full lock
always @(posedge clk)
begin
   if (srst || !emb_lock_ff)
   begin
      buf_on_ff <= 1'b0;
      buffer_start_ff <= 1'b0;
      rel_arm_ff <= 1'b0;
      rel_run_ff <= 1'b0;
      rel_cnt_ff <= 8'h00;
      buffer_release_ff <= 1'b0;
   end
   else
   begin
      buffer_start_ff <= 1'b0;
      if (!buf_on_ff && blk_valid && mb_end && block_sync_ff && mb_lock_ff)
      begin
         buf_on_ff <= 1'b1;
         buffer_start_ff <= 1'b1;
         rel_arm_ff <= 1'b1;
      end
      if (rel_arm_ff && local_extended_multiblock_clock && !rel_run_ff)
      begin
         rel_run_ff <= 1'b1;
         rel_cnt_ff <= 8'h00;
      end
      if (rel_run_ff)
      begin
         rel_cnt_ff <= rel_cnt_ff + 8'h01;
         if (rel_cnt_ff == release_buffer_delay)
         begin
            buffer_release_ff <= 1'b1;
            rel_run_ff <= 1'b0;
            rel_arm_ff <= 1'b0;
         end
      end
   end
end

endmodule

// ===== fsr_rx_ctrl_chk.sv
// assertion checker for the sync header stream controller ports
`timescale 1ns/1ps
module fsr_chk
(
   // clock and reset
   input wire clk,
   input wire srst,
   // watched user input
   input wire cfg_req,
   // watched outputs
   input wire cfg_busy,
   input wire link_enable_ff,
   input wire [3:0] serializer_preemphasis_level_ff,
   input wire block_sync_ff,
   input wire mb_lock_ff,
   input wire emb_lock_ff,
   input wire restart_block_align_ff,
   input wire sysref_request_ff,
   input wire buffer_start_ff,
   input wire buffer_release_ff,
   input wire [25:0] syndrome_ff,
   input wire syndrome_valid_ff,
   input wire fec_error_ff
);
   // -------------------------------------------------------------
   // properties, all in the one clock domain
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   property p_restart; restart_block_align_ff |-> !block_sync_ff ##1 !restart_block_align_ff;
   endproperty
   a_restart: assert property (p_restart) else $error("restart pulse wrong");
   property p_sysref; sysref_request_ff |=> !sysref_request_ff; endproperty
   a_sysref: assert property (p_sysref) else $error("sysref pulse too long");
   property p_synd; syndrome_valid_ff |-> (fec_error_ff == (syndrome_ff != 26'h0)); endproperty
   a_synd: assert property (p_synd) else $error("error flag disagrees");
   property p_fec_pair; fec_error_ff |-> syndrome_valid_ff; endproperty
   a_fec_pair: assert property (p_fec_pair) else $error("error flag alone");
   property p_take; cfg_req && !cfg_busy |=> !link_enable_ff; endproperty
   a_take: assert property (p_take) else $error("enable not cleared");
   property p_back; $fell(link_enable_ff) |-> ##[39:42] link_enable_ff; endproperty
   a_back: assert property (p_back) else $error("enable not restored");
   property p_off; !link_enable_ff |=> !block_sync_ff && !mb_lock_ff && !emb_lock_ff;
   endproperty
   a_off: assert property (p_off) else $error("sync held while disabled");
   property p_pe; !$stable(serializer_preemphasis_level_ff) |-> !link_enable_ff; endproperty
   a_pe: assert property (p_pe) else $error("setting changed while enabled");
   property p_bstart; buffer_start_ff |-> emb_lock_ff ##1 !buffer_start_ff; endproperty
   a_bstart: assert property (p_bstart) else $error("start without lock");
   property p_brel; $rose(buffer_release_ff) |-> emb_lock_ff; endproperty
   a_brel: assert property (p_brel) else $error("release without lock");
endmodule
bind fsr_rx_ctrl fsr_chk u_chk (.clk, .srst, .cfg_req, .cfg_busy, .link_enable_ff,
   .serializer_preemphasis_level_ff, .block_sync_ff, .mb_lock_ff, .emb_lock_ff,
   .restart_block_align_ff, .sysref_request_ff, .buffer_start_ff, .buffer_release_ff,
   .syndrome_ff, .syndrome_valid_ff, .fec_error_ff);

// ===== fsr_rx_ctrl_test.sv
// self-checking bench for the sync header stream controller
`timescale 1ns/1ps
`include "fsr_regs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
`define WAIT(c, n) begin k = 0; while (!(c) && k < (n)) begin @(negedge clk); k++; end end
module fsr_rx_ctrl_test;
   logic clk = 1'b0, srst = 1'b1, cfg_req = 1'b0, local_extended_multiblock_clock = 1'b0;
   logic [3:0] cfg_preemph = 4'h0;
   logic [7:0] release_buffer_delay = 8'h05;
   logic bad_sh = 1'b0, bad_pilot = 1'b0, bad_flag = 1'b0, flip_data = 1'b0;
   wire blk_valid, cfg_busy, link_enable_ff, block_sync_ff, mb_lock_ff, emb_lock_ff;
   wire restart_block_align_ff, sysref_request_ff, buffer_start_ff, buffer_release_ff;
   wire syndrome_valid_ff, fec_error_ff;
   wire [1:0] blk_sh;
   wire [63:0] blk_payload;
   wire [3:0] serializer_preemphasis_level_ff;
   wire [25:0] syndrome_ff;
   int n_errors = 0, cmp_count = 0, k, n;
   // -------------------------------------------------------------
   // clock, design and device model
   // -------------------------------------------------------------
   always #25 clk = ~clk;
   fsr_rx_ctrl dut (.clk, .srst, .blk_valid, .blk_sh, .blk_payload,
      .local_extended_multiblock_clock, .release_buffer_delay, .cfg_req, .cfg_preemph,
      .cfg_busy, .link_enable_ff, .serializer_preemphasis_level_ff, .block_sync_ff,
      .mb_lock_ff, .emb_lock_ff, .restart_block_align_ff, .sysref_request_ff,
      .buffer_start_ff, .buffer_release_ff, .syndrome_ff, .syndrome_valid_ff, .fec_error_ff);
   fsr_dev_model dev (.clk, .link_enable(link_enable_ff),
      .preemph(serializer_preemphasis_level_ff), .bad_sh, .bad_pilot, .bad_flag, .flip_data,
      .blk_valid, .blk_sh, .blk_payload);
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task cyc(input int c);
      repeat (c) @(negedge clk);
   endtask
   task tend(input string s);
      $display("test %s done", s);
   endtask
   task do_cfg(input [3:0] v);
      begin
         cfg_preemph = v;
         cfg_req = 1'b1;
         cyc(1);
         cfg_req = 1'b0;
      end
   endtask
   task relock;
      begin
         `WAIT(block_sync_ff, 300) `CHK(block_sync_ff, 1'b1)
         `WAIT(mb_lock_ff, 600) `CHK(mb_lock_ff, 1'b1)
         `WAIT(emb_lock_ff, 300) `CHK(emb_lock_ff, 1'b1)
      end
   endtask
   task stop_test;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // watchdog far beyond the expected run
   initial
   begin
      #(20000 * 50);
      n_errors++;
      stop_test;
   end
   // -------------------------------------------------------------
   // test sequence
   // -------------------------------------------------------------
   initial
   begin
      cyc(3);
      `CHK(link_enable_ff, 1'b0)
      `CHK(serializer_preemphasis_level_ff, `FSR_PE_RESET)
      srst = 1'b0;
      cyc(1);
      `CHK(link_enable_ff, 1'b1)
      `CHK(cfg_busy, 1'b0)
      tend("reset");
      relock;
      `WAIT(buffer_start_ff, 64) `CHK(buffer_start_ff, 1'b1)
      local_extended_multiblock_clock = 1'b1;
      cyc(1);
      local_extended_multiblock_clock = 1'b0;
      n = 1;
      while (buffer_release_ff !== 1'b1 && n < 64)
      begin
         cyc(1);
         n++;
      end
      `CHK(n, int'(release_buffer_delay) + 2)
      tend("buffer");
      `WAIT(syndrome_valid_ff, 64) `CHK(syndrome_ff, `FSR_PAR_ZERO)
      `CHK(fec_error_ff, 1'b0)
      cyc(20);
      flip_data = 1'b1;
      cyc(20);
      flip_data = 1'b0;
      `WAIT(syndrome_valid_ff, 64) `CHK(syndrome_ff, `FSR_PAR_POLY)
      `CHK(fec_error_ff, 1'b1)
      cyc(2);
      `WAIT(syndrome_valid_ff, 64) `CHK(syndrome_ff, `FSR_PAR_ZERO)
      tend("parity");
      bad_flag = 1'b1;
      `WAIT(sysref_request_ff, 400) `CHK(sysref_request_ff, 1'b1)
      bad_flag = 1'b0;
      `CHK(emb_lock_ff, 1'b0)
      `CHK(mb_lock_ff, 1'b1)
      relock;
      bad_pilot = 1'b1;
      `WAIT(sysref_request_ff, 400) `CHK(sysref_request_ff, 1'b1)
      bad_pilot = 1'b0;
      `CHK({mb_lock_ff, emb_lock_ff}, 2'h0)
      relock;
      tend("pilot");
      bad_sh = 1'b1;
      cyc(1);
      bad_sh = 1'b0;
      cyc(8);
      `CHK(block_sync_ff, 1'b1)
      bad_sh = 1'b1;
      `WAIT(restart_block_align_ff, 16) `CHK(restart_block_align_ff, 1'b1)
      bad_sh = 1'b0;
      `CHK(block_sync_ff, 1'b0)
      relock;
      tend("header");
      do_cfg(4'hf);
      cyc(1);
      `CHK(link_enable_ff, 1'b0)
      `CHK(cfg_busy, 1'b1)
      do_cfg(4'h3);
      `CHK(block_sync_ff, 1'b0)
      `WAIT(link_enable_ff, 60) `CHK(link_enable_ff, 1'b1)
      `CHK(serializer_preemphasis_level_ff, 4'hf)
      `CHK(cfg_busy, 1'b0)
      relock;
      tend("config");
      stop_test;
   end
endmodule
